// *** design/wesc_core.v ***
`timescale 1ns/1ps
`include "wesc_map.vh"

module wesc_core (
  input wire clk,
  input wire rstn,
  // Core execution side, all on clk.
  input wire wait_for_event_instr,
  input wire wait_for_interrupt_instr,
  input wire send_event_instr,
  input wire exc_return_instr,
  input wire exc_became_pending,
  input wire irq_preempts_unmasked,
  input wire irq_preempts_masked,
  input wire debug_enabled,
  input wire debug_halt_entry,
  input wire bus_busy,
  output reg instr_complete,
  output reg take_exception,
  output reg core_sleeping,
  // Other processors and asynchronous wakeup pins.
  input wire sev_in,
  input wire debug_event,
  input wire impl_wake,
  output reg sev_out,
  // External power controller.
  output reg bus_idle_ok,
  output reg sleep_deep,
  // Register port.
  input wire [`WESC_AW-1:0] reg_addr,
  input wire [`WESC_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`WESC_DW-1:0] reg_rdata,
  output reg irq
);

  // The block sits between the core's instruction execution and the world
  // outside it. The core tells it when a wait or a send-event instruction
  // executes, and when an exception return or a new pending exception occurs.
  // The block answers with a one-cycle completion pulse for the wait. It also
  // says whether the core must take an exception after an interrupt wait.
  // While the core is suspended the sleeping output stays high.
  // On the far side, other processors raise the send-event pin. The debug and
  // wakeup pins arrive from other clock domains, and a power controller
  // watches the bus idle output.
  // A small register port gives software control bits, a read-only state
  // view, and sticky wakeup status with a mask and one level interrupt.
  // The event latch itself is deliberately absent from that port, so
  // software can only observe its effect through the wait instructions.
  // The clock is the processor clock; every output is registered so that the
  // core and the power controller see clean, glitch-free levels.

  // One-hot sleep states.
  localparam [`WESC_ST_W-1:0] ST_RUN = 4'h1;
  localparam [`WESC_ST_W-1:0] ST_WFE_SLEEP = 4'h2;
  localparam [`WESC_ST_W-1:0] ST_WFI_DRAIN = 4'h4;
  localparam [`WESC_ST_W-1:0] ST_WFI_SLEEP = 4'h8;

  // Address match, used by both the write and the read decode.
  function hit;
    input [`WESC_AW-1:0] a;
    input [`WESC_AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [`WESC_ST_W-1:0] state_reg;
  reg [`WESC_ST_W-1:0] state_next;
  reg event_latch_reg;
  reg event_latch_next;
  reg [`WESC_CTRL_W-1:0] ctrl_reg;
  reg [`WESC_IRQ_W-1:0] irq_stat_reg;
  reg [`WESC_IRQ_W-1:0] irq_mask_reg;
  reg [`WESC_IRQ_W-1:0] irq_stat_next;
  reg [`WESC_SYNC_N-1:0] sync1_reg;
  reg [`WESC_SYNC_N-1:0] sync2_reg;
  reg sev_in_prev_reg;
  reg done_next;
  reg latch_clear;
  reg wfe_woke;
  reg wfi_woke;

  wire [`WESC_SYNC_N-1:0] async_in;
  wire sev_in_s;
  wire debug_event_s;
  wire impl_wake_s;
  wire sev_rx;
  wire debug_wake;
  wire wfe_wake;
  wire wfi_wake;
  wire latch_set;
  wire wr_ctrl;
  wire wr_irq_stat;
  wire wr_irq_mask;

  assign async_in = {impl_wake, debug_event, sev_in};

  // The send-event, debug and wakeup pins come from logic that does not share
  // this clock. A single flop could go metastable and hand different values to
  // different readers in one cycle. Two stages cost two cycles of wakeup
  // latency, which the wait instructions tolerate since completion may always
  // come later than the event.
  // Every pin input passes two flip-flops; only the second stage is read.
  genvar gi;
  generate
    for (gi = 0; gi < `WESC_SYNC_N; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (!rstn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign sev_in_s = sync2_reg[0];
  assign debug_event_s = sync2_reg[1];
  assign impl_wake_s = sync2_reg[2];

  // Edge of the incoming send-event line, so a long level counts once.
  always @(posedge clk) begin
    if (!rstn) begin
      sev_in_prev_reg <= 1'b0;
    end else begin
      sev_in_prev_reg <= sev_in_s;
    end
  end

  assign sev_rx = sev_in_s & ~sev_in_prev_reg;

  // A debug event only counts while debug is enabled.
  assign debug_wake = debug_event_s & debug_enabled;

  // The wait-for-event wakeup set has four members: a send-event from any
  // processor, a newly pending exception while the send-on-pend control bit
  // is set, an asynchronous exception that preempts the active ones, and a
  // debug event while debug is enabled.
  // The preempt term uses the masked view, because a masked exception is only
  // a wakeup here through the send-on-pend path.
  // Own send-event also marks this core, since it is one of all processors.
  assign wfe_wake = sev_rx | send_event_instr |
    (ctrl_reg[`WESC_CTRL_SEND_ON_PEND] & exc_became_pending) |
    irq_preempts_masked | debug_wake;

  // The interrupt term is judged without the priority mask bit; a core at
  // NMI priority never sees it, so only reset, halt entry, a debug event or the wakeup pin can free it.
  assign wfi_wake = irq_preempts_unmasked |
    debug_wake | impl_wake_s |
    debug_halt_entry;

  // Sources that set the event latch, whether or not a wait is pending.
  assign latch_set = wfe_wake | exc_return_instr;

  // The sequencer only accepts a wait instruction while running; the core is
  // not expected to issue instructions while it is suspended, and any that
  // arrive then are ignored.
  // A wait-for-event with the latch set finishes at once and consumes the
  // latch. With the latch clear, a wakeup in the same cycle also finishes at
  // once, otherwise the core sleeps until the next wakeup.
  // A wait-for-interrupt can be turned into a plain no-operation by control.
  // Otherwise it may first drain the bus, then sleeps until one of its own
  // wakeup sources appears.
  // Sleep sequencing and instruction completion.
  always @* begin
    state_next = state_reg;
    done_next = 1'b0;
    latch_clear = 1'b0;
    wfe_woke = 1'b0;
    wfi_woke = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (wait_for_event_instr) begin
          if (event_latch_reg) begin
            latch_clear = 1'b1;
            done_next = 1'b1;
          end else if (wfe_wake) begin
            // The wakeup lands in the same cycle; sleeping would be pointless.
            done_next = 1'b1;
            wfe_woke = 1'b1;
          end else begin
            state_next = ST_WFE_SLEEP;
          end
        end else if (wait_for_interrupt_instr) begin
          if (ctrl_reg[`WESC_CTRL_WFI_AS_NOP]) begin
            done_next = 1'b1;
          end else if (wfi_wake) begin
            done_next = 1'b1;
            wfi_woke = 1'b1;
          end else if (ctrl_reg[`WESC_CTRL_DRAIN]) begin
            state_next = ST_WFI_DRAIN;
          end else begin
            state_next = ST_WFI_SLEEP;
          end
        end
      end
      ST_WFE_SLEEP: begin
        if (wfe_wake) begin
          state_next = ST_RUN;
          done_next = 1'b1;
          wfe_woke = 1'b1;
        end
      end
      ST_WFI_DRAIN: begin
        // A wakeup during the drain ends the wait; the drain is best effort.
        if (wfi_wake) begin
          state_next = ST_RUN;
          done_next = 1'b1;
          wfi_woke = 1'b1;
        end else if (!bus_busy) begin
          state_next = ST_WFI_SLEEP;
        end
      end
      ST_WFI_SLEEP: begin
        if (wfi_wake) begin
          state_next = ST_RUN;
          done_next = 1'b1;
          wfi_woke = 1'b1;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // The latch is one bit for this processor only. Reset clears it, the
  // wakeup sources and exception returns set it, and only a wait-for-event
  // that finds it set clears it again.
  // Software that polls a flag around the wait relies on that one bit never
  // dropping an event, which is why the set path is applied last below.
  // Set beats clear so that a coinciding event is never lost. Resuming from
  // an event-wait sleep never clears the latch, so the wakeup that ended it stays recorded.
  always @* begin
    event_latch_next = event_latch_reg;
    if (latch_clear) begin
      event_latch_next = 1'b0;
    end
    if (latch_set) begin
      event_latch_next = 1'b1;
    end
  end

  // The latch has no path to the register port in either direction.
  always @(posedge clk) begin
    if (!rstn) begin
      event_latch_reg <= 1'b0;
      state_reg <= ST_RUN;
    end else begin
      event_latch_reg <= event_latch_next;
      state_reg <= state_next;
    end
  end

  // The completion pulse lasts one cycle. The exception flag rides along with
  // it only for an interrupt wait that ended by a wakeup; a wake that was
  // allowed by ignoring the priority mask must not force an exception that the
  // mask would still hold off.
  // The send-event output is a one-cycle pulse to the other processors.
  // Completion outputs; the exception decision uses the masked priority.
  always @(posedge clk) begin
    if (!rstn) begin
      instr_complete <= 1'b0;
      take_exception <= 1'b0;
      core_sleeping <= 1'b0;
      sev_out <= 1'b0;
    end else begin
      instr_complete <= done_next;
      take_exception <= done_next & wfi_woke & irq_preempts_masked;
      core_sleeping <= (state_next != ST_RUN);
      sev_out <= send_event_instr;
    end
  end

  // The idle report is the only promise made to the power controller. It is
  // given only in the interrupt sleep state, because an event wait must stay
  // ready to resume with low latency and cannot afford a clock restart.
  // The deep sleep output is a plain copy of the control bit; what the
  // controller does with it is up to the system.
  // Power controller may gate clocks only when fully asleep on a quiet bus.
  always @(posedge clk) begin
    if (!rstn) begin
      bus_idle_ok <= 1'b0;
      sleep_deep <= 1'b0;
    end else begin
      bus_idle_ok <= (state_next == ST_WFI_SLEEP) & ~bus_busy;
      sleep_deep <= ctrl_reg[`WESC_CTRL_SLEEP_DEEP];
    end
  end

  assign wr_ctrl = reg_wr & hit(reg_addr, `WESC_OFF_CTRL);
  assign wr_irq_stat = reg_wr & hit(reg_addr, `WESC_OFF_IRQ_STAT);
  assign wr_irq_mask = reg_wr & hit(reg_addr, `WESC_OFF_IRQ_MASK);

  // The register port never waits: a write lands at its own edge and read
  // data stands only in the next cycle. Unmapped writes are dropped.
  // The status bits record which kind of wait ended by a wakeup and whether a
  // send-event came in from another processor. They are only a convenience for
  // software; the wait behaviour does not depend on them.
  // Sticky status: write one to clear, and a fresh event in the same cycle
  // survives the clear.
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_irq_stat) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[`WESC_IRQ_W-1:0];
    end
    irq_stat_next[`WESC_IRQ_WFE_WAKE] = irq_stat_next[`WESC_IRQ_WFE_WAKE] | wfe_woke;
    irq_stat_next[`WESC_IRQ_WFI_WAKE] = irq_stat_next[`WESC_IRQ_WFI_WAKE] | wfi_woke;
    irq_stat_next[`WESC_IRQ_SEV_RX] = irq_stat_next[`WESC_IRQ_SEV_RX] | sev_rx;
  end

  // Control, mask and status registers.
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= `WESC_CTRL_RESET;
      irq_mask_reg <= `WESC_IRQ_RESET;
      irq_stat_reg <= `WESC_IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[`WESC_CTRL_W-1:0];
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= reg_wdata[`WESC_IRQ_W-1:0];
      end
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Level interrupt, registered so it is glitch free.
  always @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= {`WESC_DW{1'b0}};
    end else if (reg_rd) begin
      if (hit(reg_addr, `WESC_OFF_CTRL)) begin
        reg_rdata <= {{(`WESC_DW-`WESC_CTRL_W){1'b0}}, ctrl_reg};
      end else if (hit(reg_addr, `WESC_OFF_STATUS)) begin
        reg_rdata <= {{(`WESC_DW-`WESC_ST_W){1'b0}}, state_reg};
      end else if (hit(reg_addr, `WESC_OFF_IRQ_STAT)) begin
        reg_rdata <= {{(`WESC_DW-`WESC_IRQ_W){1'b0}}, irq_stat_reg};
      end else if (hit(reg_addr, `WESC_OFF_IRQ_MASK)) begin
        reg_rdata <= {{(`WESC_DW-`WESC_IRQ_W){1'b0}}, irq_mask_reg};
      end else begin
        reg_rdata <= {`WESC_DW{1'b0}};
      end
    end else begin
      reg_rdata <= {`WESC_DW{1'b0}};
    end
  end

endmodule

// *** design/wesc_map.vh ***
`ifndef WESC_MAP_VH
`define WESC_MAP_VH
`define WESC_AW 8
`define WESC_DW 32
`define WESC_OFF_CTRL 8'h00
`define WESC_OFF_STATUS 8'h04
`define WESC_OFF_IRQ_STAT 8'h08
`define WESC_OFF_IRQ_MASK 8'h0c
`define WESC_CTRL_SEND_ON_PEND 0
`define WESC_CTRL_WFI_AS_NOP 1
`define WESC_CTRL_DRAIN 2
`define WESC_CTRL_SLEEP_DEEP 3
`define WESC_CTRL_W 4
`define WESC_CTRL_RESET 4'h0
`define WESC_IRQ_WFE_WAKE 0
`define WESC_IRQ_WFI_WAKE 1
`define WESC_IRQ_SEV_RX 2
`define WESC_IRQ_W 3
`define WESC_IRQ_RESET 3'h0
`define WESC_ST_W 4
`define WESC_SYNC_N 3
`endif

// *** testbench/wesc_core_properties.sv ***
`timescale 1ns/1ps
module wesc_core_properties (
  input wire clk,
  input wire rstn,
  input wire wait_for_interrupt_instr,
  input wire send_event_instr,
  input wire irq_preempts_unmasked,
  input wire irq_preempts_masked,
  input wire debug_halt_entry,
  input wire instr_complete,
  input wire take_exception,
  input wire core_sleeping,
  input wire sev_out,
  input wire bus_idle_ok
);
  // The outputs do not say which wait put the core to sleep, so remember it here.
  reg in_wfi_reg;
  always @(posedge clk) begin
    if (!rstn)
      in_wfi_reg <= 1'b0;
    else if (!core_sleeping)
      in_wfi_reg <= wait_for_interrupt_instr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wfi_wake;
    in_wfi_reg && core_sleeping && irq_preempts_unmasked;
  endsequence
  sequence s_resumed;
    instr_complete && !core_sleeping;
  endsequence
  a_wfi_irq_wake: assert property (s_wfi_wake |=> s_resumed)
    else $error("no resume on interrupt");
  a_exc_decision: assert property (s_wfi_wake |=> take_exception == $past(irq_preempts_masked))
    else $error("wrong exception choice");
  a_exc_with_done: assert property (take_exception |-> instr_complete)
    else $error("exception without completion");
  a_halt_wake: assert property (in_wfi_reg && core_sleeping && debug_halt_entry |=> s_resumed)
    else $error("no resume on halt entry");
  a_wfe_irq_wake: assert property (!in_wfi_reg && core_sleeping && irq_preempts_masked |=> s_resumed)
    else $error("no resume from event wait");
  a_sev_broadcast: assert property (send_event_instr |=> sev_out)
    else $error("send event not broadcast");
  a_idle_only_asleep: assert property ($rose(bus_idle_ok) |-> core_sleeping && in_wfi_reg)
    else $error("idle reported while awake");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !core_sleeping && !instr_complete && !sev_out)
    else $error("outputs active after reset");
endmodule

bind wesc_core wesc_core_properties u_props (
  .clk(clk),
  .rstn(rstn),
  .wait_for_interrupt_instr(wait_for_interrupt_instr),
  .send_event_instr(send_event_instr),
  .irq_preempts_unmasked(irq_preempts_unmasked),
  .irq_preempts_masked(irq_preempts_masked),
  .debug_halt_entry(debug_halt_entry),
  .instr_complete(instr_complete),
  .take_exception(take_exception),
  .core_sleeping(core_sleeping),
  .sev_out(sev_out),
  .bus_idle_ok(bus_idle_ok)
);

// *** testbench/wesc_core_test.sv ***
`timescale 1ns/1ps
`include "wesc_map.vh"
module wesc_core_test;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg bus_busy = 1'b1;
  reg dbg_en = 1'b1;
  wire sleep_deep;
  reg [5:0] pv = 6'h0;
  reg [4:0] src = 5'h0;
  reg [`WESC_AW-1:0] reg_addr = 8'h00;
  reg [`WESC_DW-1:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire instr_complete, take_exception, core_sleeping, sev_in, sev_out, bus_idle_ok, irq, peer_evt, pwr_off;
  wire [`WESC_DW-1:0] reg_rdata;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int i;
  int k;
  always #20 clk = ~clk;
  wesc_core dut (.clk(clk), .rstn(rstn), .wait_for_event_instr(pv[0]), .wait_for_interrupt_instr(pv[1]),
    .send_event_instr(pv[2]), .exc_return_instr(pv[3]), .exc_became_pending(pv[4]),
    .irq_preempts_unmasked(src[0]), .irq_preempts_masked(src[4]), .debug_enabled(dbg_en),
    .debug_halt_entry(src[1]), .bus_busy(bus_busy), .instr_complete(instr_complete),
    .take_exception(take_exception), .core_sleeping(core_sleeping), .sev_in(sev_in), .debug_event(src[3]),
    .impl_wake(src[2]), .sev_out(sev_out), .bus_idle_ok(bus_idle_ok), .sleep_deep(sleep_deep), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  wesc_partner peer (.clk(clk), .rstn(rstn), .fire(pv[5]), .sev_out(sev_out), .bus_idle_ok(bus_idle_ok),
    .sev_in(sev_in), .peer_evt_reg(peer_evt), .pwr_off_reg(pwr_off));
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: flag %b", $time, got);
    end
  endtask
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: read %h", $time, got);
    end
  endtask
  task pulse(input logic [5:0] v);
    @(posedge clk) pv <= v;
    @(posedge clk) pv <= 6'h0;
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk32(reg_rdata, e);
  endtask
  // Completion may lag the wake by the synchroniser, so poll under a bound.
  task wait_done;
    for (i = 0; i < 40 && instr_complete !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk1(instr_complete, 1'b1);
  endtask
  // A hang is cut short long after the sequence should have ended.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h1);
    rd_chk(8'h10, 32'h0);
    wr(8'h0c, 32'h7);
    pulse(6'h08);
    pulse(6'h01);
    chk1(instr_complete, 1'b1);
    pulse(6'h01);
    chk1(core_sleeping, 1'b1);
    rd_chk(8'h04, 32'h2);
    pulse(6'h20);
    wait_done;
    rd_chk(8'h08, 32'h5);
    chk1(irq, 1'b1);
    wr(8'h08, 32'h7);
    rd_chk(8'h08, 32'h0);
    chk1(irq, 1'b0);
    pulse(6'h01);
    chk1(instr_complete, 1'b1);
    pulse(6'h05);
    chk1(instr_complete, 1'b1);
    pulse(6'h01);
    chk1(instr_complete, 1'b1);
    chk1(peer_evt, 1'b1);
    wr(8'h00, 32'h1);
    pulse(6'h01);
    chk1(core_sleeping, 1'b1);
    pulse(6'h10);
    wait_done;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h7);
    // The first four passes wake the interrupt wait from different sources; the last repeats the interrupt with the masked view set.
    for (k = 0; k < 5; k++) begin
      pulse(6'h02);
      chk1(bus_idle_ok, 1'b0);
      rd_chk(8'h04, 32'h8);
      @(posedge clk) bus_busy <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk1(pwr_off, 1'b1);
      @(posedge clk) src <= (k == 4) ? 5'h11 : 5'h01 << k;
      wait_done;
      chk1(take_exception, k == 4);
      @(posedge clk) src <= 5'h0;
      bus_busy <= 1'b1;
      repeat (4) @(posedge clk);
    end
    // With debug disabled a debug event must not end the interrupt wait.
    @(posedge clk) dbg_en <= 1'b0;
    pulse(6'h02);
    @(posedge clk) src <= 5'h08;
    repeat (6) @(posedge clk);
    #1 chk1(core_sleeping, 1'b1);
    @(posedge clk) src <= 5'h01;
    wait_done;
    @(posedge clk) src <= 5'h0;
    dbg_en <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h08, 32'h2);
    wr(8'h00, 32'h8);
    @(posedge clk);
    #1 chk1(sleep_deep, 1'b1);
    wr(8'h00, 32'h2);
    pulse(6'h02);
    chk1(instr_complete, 1'b1);
    wr(8'h00, 32'h4);
    pulse(6'h02);
    rd_chk(8'h04, 32'h4);
    @(posedge clk) bus_busy <= 1'b0;
    rd_chk(8'h04, 32'h8);
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk1(core_sleeping, 1'b0);
    pulse(6'h01);
    chk1(core_sleeping, 1'b1);
    @(posedge clk) src <= 5'h10;
    wait_done;
    @(posedge clk) src <= 5'h0;
    print_verdict;
  end
endmodule

// *** testbench/wesc_partner.sv ***
`timescale 1ns/1ps
// Stands for a second processor and the external power controller.
module wesc_partner (
  input wire clk,
  input wire rstn,
  input wire fire,
  input wire sev_out,
  input wire bus_idle_ok,
  output wire sev_in,
  output reg peer_evt_reg,
  output reg pwr_off_reg
);
  reg [2:0] hold_reg;
  // The peer event is held several cycles so a two-stage synchroniser cannot miss it.
  assign sev_in = (hold_reg != 3'h0);
  always @(posedge clk) begin
    if (!rstn) begin
      hold_reg <= 3'h0;
      peer_evt_reg <= 1'b0;
      pwr_off_reg <= 1'b0;
    end else begin
      hold_reg <= fire ? 3'h5 : hold_reg - {2'h0, sev_in};
      peer_evt_reg <= peer_evt_reg | sev_out;
      pwr_off_reg <= bus_idle_ok;
    end
  end
endmodule
